// ### rtl/overtemp_defs.svh
`ifndef OVERTEMP_DEFS_SVH
`define OVERTEMP_DEFS_SVH

// command codes
`define CMD_FAULT_LIMIT     8'h4f
`define CMD_FAULT_ACTION    8'h50
`define CMD_WARN_LIMIT      8'h51
`define CMD_TEMP_STATUS     8'h7d

// limit word layout
`define LIM_EXP_MSB         15
`define LIM_EXP_LSB         11
`define LIM_MAN_MSB         10
`define LIM_MAN_LSB         0
`define LIM_EXP_RESET       5'h00

// action byte layout
`define ACT_MODE_MSB        7
`define ACT_MODE_LSB        6
`define ACT_RETRY_MSB       5
`define ACT_RETRY_LSB       3
`define ACT_DELAY_MSB       2
`define ACT_DELAY_LSB       0
`define RETRY_FOREVER       3'h7
`define RETRY_LATCH         3'h0

// temperature status byte layout
`define STS_FAULT_BIT       7
`define STS_WARN_BIT        6
`define STS_INVALID_BIT     1

// fixed point and temperature figures, degrees c
`define FIX_FRAC            16
`define FIX_W               48
`define LIMIT_OFF_DEG       255
`define NVM_MIN_DEG         0
`define NVM_MAX_DEG         160
`define HYST_DEG            20

// timing
`define MCLK_PERIOD_NS      50
`define MS_NS               1000000
`define MS_CYCLES           (`MS_NS / `MCLK_PERIOD_NS)
`define LONG_DELAY_MS       10

`endif

// ### rtl/overtemp_pkg.sv
package overtemp_pkg;

	typedef enum logic [7:0] {
		ST_IDLE     = 8'h01,
		ST_RUN      = 8'h02,
		ST_DELAY    = 8'h04,
		ST_OFF_WAIT = 8'h08,
		ST_STUCK    = 8'h10,
		ST_HICCUP   = 8'h20,
		ST_START    = 8'h40,
		ST_LATCHED  = 8'h80
	} sup_state_t;

	typedef enum logic [1:0] {
		ACT_IGNORE    = 2'b00,
		ACT_DELAYED   = 2'b01,
		ACT_IMMEDIATE = 2'b10,
		ACT_UNTIL_COOL = 2'b11
	} fault_action_t;

	typedef struct packed {
		logic [4:0]  exponent;
		logic [10:0] mantissa;
	} limit_word_t;

	typedef struct packed {
		logic temp_fault_flag;
		logic temp_warning_flag;
		logic invalid_data;
	} temp_status_t;

endpackage

// ### rtl/linear_to_fixed.sv
`timescale 1ns/10ps
`include "overtemp_defs.svh"

// linear word (mantissa * 2^exponent) to signed fixed point, FRAC fraction bits
module linear_to_fixed #(
	parameter int FRAC = `FIX_FRAC,
	parameter int W    = `FIX_W
) (
	input  wire logic [15:0]         word,
	output logic signed [W-1:0]      fixed
);
	logic signed [W-1:0] ext;
	logic        [5:0]   shamt;

	always_comb begin
		ext   = {{(W-11){word[10]}}, word[10:0]};
		shamt = {word[15], word[15:11]} + 6'(FRAC);
		fixed = ext <<< shamt;
	end
endmodule // linear_to_fixed

// ### rtl/overtemp_fault_supervisor.sv
`timescale 1ns/10ps
`include "overtemp_defs.svh"

// Operation
// - fault limit: 16-bit word, exponent resets zero
// - warning limit: same layout, mantissa from store
// - unsupported limit writes flag invalid, alert host
// - compare thresholds at full written resolution
// - store/restore rounds limits to whole 0..160, keeps 255
// - fault limit 255 disables fault detection
// - warning limit 255 disables warning detection
// - fault sets summary, fault flag, alert
// - warning sets summary, warning flag, alert
// - fault released only below warning threshold
// - bad warning limit: release twenty below fault
// - action modes ignore, delayed, immediate, until cool
// - retry field: latch, counted retries, forever
// - hot restart attempts still count toward limit
// - delay field selects shutdown delay, hiccup
// - clear while between thresholds may stick
module overtemp_fault_supervisor
	import overtemp_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [15:0] cmd_wdata,
	output logic      [15:0] cmd_rdata,
	output logic             cmd_rd_ack,
	input  wire logic        nvm_load,
	input  wire logic [15:0] nvm_fault_word,
	input  wire logic [15:0] nvm_warn_word,
	input  wire logic [7:0]  nvm_action,
	input  wire logic        nvm_store,
	output logic      [15:0] nvm_fault_image,
	output logic      [15:0] nvm_warn_image,
	output logic      [7:0]  nvm_action_image,
	input  wire logic        temp_valid,
	input  wire logic [15:0] temp_sample,
	input  wire logic        clear_faults,
	input  wire logic        output_on,
	input  wire logic        start_done,
	input  wire logic [7:0]  ton_rise_ms,
	output logic             shutdown,
	output logic             restart_pulse,
	output temp_status_t     status,
	output logic             temp_summary,
	output logic             alert_req
);
	localparam int W = `FIX_W;
	localparam logic signed [W-1:0] DEG_OFF  = W'(`LIMIT_OFF_DEG) <<< `FIX_FRAC;
	localparam logic signed [W-1:0] DEG_MIN  = W'(`NVM_MIN_DEG) <<< `FIX_FRAC;
	localparam logic signed [W-1:0] DEG_MAX  = W'(`NVM_MAX_DEG) <<< `FIX_FRAC;
	localparam logic signed [W-1:0] DEG_HYST = W'(`HYST_DEG) <<< `FIX_FRAC;
	localparam logic signed [W-1:0] HALF_DEG = W'(1) <<< (`FIX_FRAC - 1);

	// ---------------- configuration registers ----------------
	limit_word_t fault_lim_r, fault_lim_nxt;
	limit_word_t warn_lim_r, warn_lim_nxt;
	logic [7:0]  action_r, action_nxt;
	logic        load_pend_r, load_pend_nxt;
	logic [15:0] fault_img_nxt, warn_img_nxt;
	logic [7:0]  act_img_nxt;

	logic signed [W-1:0] fault_fix, warn_fix, wr_fix, samp_fix, nvf_fix, nvw_fix;

	linear_to_fixed #(.FRAC(`FIX_FRAC), .W(W)) u_fault (.word(fault_lim_r),    .fixed(fault_fix));
	linear_to_fixed #(.FRAC(`FIX_FRAC), .W(W)) u_warn  (.word(warn_lim_r),     .fixed(warn_fix));
	linear_to_fixed #(.FRAC(`FIX_FRAC), .W(W)) u_wr    (.word(cmd_wdata),      .fixed(wr_fix));
	linear_to_fixed #(.FRAC(`FIX_FRAC), .W(W)) u_samp  (.word(temp_sample),    .fixed(samp_fix));
	linear_to_fixed #(.FRAC(`FIX_FRAC), .W(W)) u_nvf   (.word(nvm_fault_word), .fixed(nvf_fix));
	linear_to_fixed #(.FRAC(`FIX_FRAC), .W(W)) u_nvw   (.word(nvm_warn_word),  .fixed(nvw_fix));

	// nearest whole degree inside the stored range; the disable code survives
	function automatic limit_word_t round_limit(input logic signed [W-1:0] f);
		logic signed [W-1:0] r;
		r = (f + HALF_DEG) >>> `FIX_FRAC;
		round_limit.exponent = `LIM_EXP_RESET;
		if (f == DEG_OFF)
			round_limit.mantissa = 11'(`LIMIT_OFF_DEG);
		else if (r < W'(`NVM_MIN_DEG))
			round_limit.mantissa = 11'(`NVM_MIN_DEG);
		else if (r > W'(`NVM_MAX_DEG))
			round_limit.mantissa = 11'(`NVM_MAX_DEG);
		else
			round_limit.mantissa = r[10:0];
	endfunction

	logic wr_limit, wr_bad;

	always_comb begin
		wr_limit = cmd_wr && (cmd_code == `CMD_FAULT_LIMIT || cmd_code == `CMD_WARN_LIMIT);
		wr_bad   = wr_limit && !(wr_fix == DEG_OFF || (wr_fix >= DEG_MIN && wr_fix <= DEG_MAX));
		fault_lim_nxt = fault_lim_r;
		warn_lim_nxt  = warn_lim_r;
		action_nxt    = action_r;
		load_pend_nxt = 1'b0;
		fault_img_nxt = nvm_fault_image;
		warn_img_nxt  = nvm_warn_image;
		act_img_nxt   = nvm_action_image;
		if (load_pend_r || nvm_load) begin
			fault_lim_nxt = round_limit(nvf_fix);
			warn_lim_nxt  = round_limit(nvw_fix);
			action_nxt    = nvm_action;
		end else if (nvm_store) begin
			fault_lim_nxt = round_limit(fault_fix);
			warn_lim_nxt  = round_limit(warn_fix);
			fault_img_nxt = round_limit(fault_fix);
			warn_img_nxt  = round_limit(warn_fix);
			act_img_nxt   = action_r;
		end else if (cmd_wr && !wr_bad) begin
			case (cmd_code)
				`CMD_FAULT_LIMIT:  fault_lim_nxt = cmd_wdata;
				`CMD_WARN_LIMIT:   warn_lim_nxt  = cmd_wdata;
				`CMD_FAULT_ACTION: action_nxt    = cmd_wdata[7:0];
				default:           action_nxt    = action_r;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fault_lim_r      <= '{exponent: `LIM_EXP_RESET, mantissa: 11'h000};
			warn_lim_r       <= '{exponent: `LIM_EXP_RESET, mantissa: 11'h000};
			action_r         <= 8'h00;
			load_pend_r      <= 1'b1;
			nvm_fault_image  <= 16'h0000;
			nvm_warn_image   <= 16'h0000;
			nvm_action_image <= 8'h00;
		end else begin
			fault_lim_r      <= fault_lim_nxt;
			warn_lim_r       <= warn_lim_nxt;
			action_r         <= action_nxt;
			load_pend_r      <= load_pend_nxt;
			nvm_fault_image  <= fault_img_nxt;
			nvm_warn_image   <= warn_img_nxt;
			nvm_action_image <= act_img_nxt;
		end
	end

	// ---------------- register reads ----------------
	logic [15:0] rdata_nxt;

	always_comb begin
		rdata_nxt = 16'h0000;
		case (cmd_code)
			`CMD_FAULT_LIMIT:  rdata_nxt = fault_lim_r;
			`CMD_WARN_LIMIT:   rdata_nxt = warn_lim_r;
			`CMD_FAULT_ACTION: rdata_nxt = {8'h00, action_r};
			`CMD_TEMP_STATUS: begin
				rdata_nxt[`STS_FAULT_BIT]   = status.temp_fault_flag;
				rdata_nxt[`STS_WARN_BIT]    = status.temp_warning_flag;
				rdata_nxt[`STS_INVALID_BIT] = status.invalid_data;
			end
			default:           rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_rdata  <= 16'h0000;
			cmd_rd_ack <= 1'b0;
		end else begin
			cmd_rdata  <= cmd_rd ? rdata_nxt : cmd_rdata;
			cmd_rd_ack <= cmd_rd;
		end
	end

	// ---------------- comparisons ----------------
	logic                fault_en, warn_en, fault_hit, warn_hit, cool_hit;
	logic signed [W-1:0] release_fix;
	logic                cond_r, cond_nxt, cool_r, cool_nxt, hot_r, hot_nxt;

	always_comb begin
		fault_en    = fault_fix != DEG_OFF;
		warn_en     = warn_fix != DEG_OFF;
		release_fix = (!warn_en || warn_fix > fault_fix) ? fault_fix - DEG_HYST : warn_fix;
		fault_hit   = temp_valid && fault_en && samp_fix >= fault_fix;
		warn_hit    = temp_valid && warn_en && samp_fix >= warn_fix;
		cool_hit    = temp_valid && samp_fix < release_fix;
		cond_nxt    = fault_hit ? 1'b1 : (cool_hit ? 1'b0 : cond_r);
		cool_nxt    = temp_valid ? samp_fix < release_fix : cool_r;
		hot_nxt     = temp_valid ? fault_hit : hot_r;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cond_r <= 1'b0;
			cool_r <= 1'b1;
			hot_r  <= 1'b0;
		end else begin
			cond_r <= cond_nxt;
			cool_r <= cool_nxt;
			hot_r  <= hot_nxt;
		end
	end

	// ---------------- status ----------------
	temp_status_t sts_nxt;

	always_comb begin
		sts_nxt.temp_fault_flag   = fault_hit || (status.temp_fault_flag && !clear_faults);
		sts_nxt.temp_warning_flag = warn_hit || (status.temp_warning_flag && !clear_faults);
		sts_nxt.invalid_data      = wr_bad || (status.invalid_data && !clear_faults);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			status <= '0;
		else
			status <= sts_nxt;
	end

	assign temp_summary = status.temp_fault_flag || status.temp_warning_flag;
	assign alert_req    = |status;

	// ---------------- millisecond tick ----------------
	logic [31:0] ms_cnt_r, ms_cnt_nxt;
	logic        ms_tick;

	always_comb begin
		ms_tick    = ms_cnt_r == 32'(MS_CYCLES - 1);
		ms_cnt_nxt = ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ms_cnt_r <= 32'h0000_0000;
		else
			ms_cnt_r <= ms_cnt_nxt;
	end

	// ---------------- shutdown and retry control ----------------
	sup_state_t    state_r, state_nxt;
	logic [15:0]   tmr_r, tmr_nxt;
	logic [2:0]    tries_r, tries_nxt;
	fault_action_t mode;
	logic [2:0]    retry, dsel;
	logic [15:0]   delay_ms, hiccup_ms;
	logic [2:0]    hmul;
	logic          tmr_done, restart_nxt;

	always_comb begin
		mode  = fault_action_t'(action_r[`ACT_MODE_MSB:`ACT_MODE_LSB]);
		retry = action_r[`ACT_RETRY_MSB:`ACT_RETRY_LSB];
		dsel  = action_r[`ACT_DELAY_MSB:`ACT_DELAY_LSB];
		case (dsel)
			3'h0:       hmul = 3'h1;
			3'h1, 3'h2: hmul = 3'h2;
			3'h3, 3'h4, 3'h5: hmul = 3'h3;
			default:    hmul = 3'h4;
		endcase
		delay_ms  = (dsel == 3'h0) ? 16'(`LONG_DELAY_MS) : {13'h0000, dsel};
		hiccup_ms = 16'(ton_rise_ms) * 16'(hmul);
		tmr_done  = tmr_r == 16'h0000;
	end

	// shut down, then either wait out a hiccup or latch off once the attempts are spent
	function automatic sup_state_t shut_entry(input logic [2:0] rt, input logic [2:0] done);
		if (rt == `RETRY_LATCH || (rt != `RETRY_FOREVER && done >= rt))
			shut_entry = ST_LATCHED;
		else
			shut_entry = ST_HICCUP;
	endfunction

	always_comb begin
		state_nxt   = state_r;
		tmr_nxt     = (ms_tick && !tmr_done) ? tmr_r - 16'h0001 : tmr_r;
		tries_nxt   = tries_r;
		restart_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				tries_nxt = 3'h0;
				if (output_on)
					state_nxt = ST_RUN;
			end
			ST_RUN, ST_START: begin
				if (state_r == ST_START && start_done) begin
					state_nxt = ST_RUN;
					tries_nxt = 3'h0;
				end
				if (fault_hit) begin
					case (mode)
						ACT_DELAYED: begin
							state_nxt = ST_DELAY;
							tmr_nxt   = delay_ms;
						end
						ACT_IMMEDIATE: begin
							state_nxt = shut_entry(retry, tries_r);
							tmr_nxt   = hiccup_ms;
						end
						ACT_UNTIL_COOL: state_nxt = ST_OFF_WAIT;
						default:        state_nxt = state_r;
					endcase
				end
			end
			ST_DELAY: begin
				if (cool_hit)
					state_nxt = ST_RUN;
				else if (tmr_done) begin
					state_nxt = cond_r ? shut_entry(retry, tries_r) : ST_RUN;
					tmr_nxt   = hiccup_ms;
				end
			end
			ST_OFF_WAIT: begin
				if (cool_hit) begin
					state_nxt = shut_entry(retry, tries_r);
					tmr_nxt   = hiccup_ms;
				end else if (clear_faults && !hot_r)
					state_nxt = ST_STUCK;
			end
			ST_STUCK: begin
				if (fault_hit)
					state_nxt = ST_OFF_WAIT;
			end
			ST_HICCUP: begin
				if (tmr_done) begin
					tries_nxt = tries_r + 3'h1;
					if (retry != `RETRY_FOREVER && tries_r + 3'h1 >= retry)
						state_nxt = cool_r ? ST_START : ST_LATCHED;
					else if (cool_r)
						state_nxt = ST_START;
					else
						tmr_nxt = hiccup_ms;
					restart_nxt = cool_r;
					if (retry == `RETRY_FOREVER)
						tries_nxt = tries_r;
				end
			end
			ST_LATCHED: state_nxt = ST_LATCHED;
			default:    state_nxt = ST_IDLE;
		endcase
		if (!output_on) begin
			state_nxt = ST_IDLE;
			tries_nxt = 3'h0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r       <= ST_IDLE;
			tmr_r         <= 16'h0000;
			tries_r       <= 3'h0;
			restart_pulse <= 1'b0;
			shutdown      <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			tmr_r         <= tmr_nxt;
			tries_r       <= tries_nxt;
			restart_pulse <= restart_nxt;
			shutdown      <= state_nxt inside {ST_OFF_WAIT, ST_STUCK, ST_HICCUP, ST_LATCHED};
		end
	end
endmodule // overtemp_fault_supervisor

// ### dv/overtemp_checker_assertions.sv
`timescale 1ns/10ps
`include "overtemp_defs.svh"
module overtemp_checker
	import overtemp_pkg::*;
#(
	parameter int MS_CYCLES = 20000
) (
	input wire logic         mclk,
	input wire logic         rst,
	input wire logic         cmd_wr,
	input wire logic         cmd_rd,
	input wire logic  [7:0]  cmd_code,
	input wire logic  [15:0] cmd_wdata,
	input wire logic         cmd_rd_ack,
	input wire logic         nvm_load,
	input wire logic         nvm_store,
	input wire logic         temp_valid,
	input wire logic         clear_faults,
	input wire logic         shutdown,
	input wire logic         restart_pulse,
	input wire temp_status_t status,
	input wire logic         temp_summary,
	input wire logic         alert_req
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// limit write of a whole value from 161 to 254 degrees
	wire bad_lim = cmd_wr && !nvm_load && !nvm_store && cmd_wdata[15:11] == 5'h00
		&& cmd_wdata[10:0] > 11'h0a0 && cmd_wdata[10:0] < 11'h0ff
		&& (cmd_code == `CMD_FAULT_LIMIT || cmd_code == `CMD_WARN_LIMIT);

	a_read_ack_next: assert property (cmd_rd |=> cmd_rd_ack)
		else $error("read not acknowledged");
	a_ack_needs_read: assert property (cmd_rd_ack |-> $past(cmd_rd))
		else $error("acknowledge without read");
	a_summary_flags: assert property (temp_summary == (status.temp_fault_flag || status.temp_warning_flag))
		else $error("summary differs from flags");
	a_alert_flags: assert property (alert_req == (|status))
		else $error("alert differs from flags");
	a_fault_sticky: assert property (status.temp_fault_flag && !clear_faults |=> status.temp_fault_flag)
		else $error("fault flag dropped");
	a_fault_by_sample: assert property ($rose(status.temp_fault_flag) |-> $past(temp_valid))
		else $error("fault flag without sample");
	a_warn_by_sample: assert property ($rose(status.temp_warning_flag) |-> $past(temp_valid))
		else $error("warning flag without sample");
	a_invalid_flagged: assert property (bad_lim |=> status.invalid_data)
		else $error("bad limit not flagged");
	a_restart_from_off: assert property (restart_pulse |-> $past(shutdown) ##1 !restart_pulse)
		else $error("restart not from shutdown");

	c_shutdown: cover property ($rose(shutdown));
	c_restart: cover property (restart_pulse);
	c_invalid: cover property ($rose(status.invalid_data));
endmodule // overtemp_checker

bind overtemp_fault_supervisor overtemp_checker #(.MS_CYCLES(MS_CYCLES)) overtemp_checker_i (.*);

// ### dv/pmbus_host_model.sv
`timescale 1ns/10ps
module pmbus_host_model (
	input  wire logic        mclk,
	input  wire logic [15:0] cmd_rdata,
	input  wire logic        cmd_rd_ack,
	output logic             cmd_wr,
	output logic             cmd_rd,
	output logic      [7:0]  cmd_code,
	output logic      [15:0] cmd_wdata
);
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end

	// word write; released lines show the inverse
	task automatic put(input logic [7:0] code, input logic [15:0] data);
		@(posedge mclk);
		cmd_wr <= 1'b1;
		cmd_code <= code;
		cmd_wdata <= data;
		@(posedge mclk);
		cmd_wr <= 1'b0;
		cmd_code <= ~code;
		cmd_wdata <= ~data;
	endtask

	task automatic put_byte(input logic [7:0] code, input logic [7:0] data);
		put(code, {8'h00, data});
	endtask

	task automatic get(input logic [7:0] code, output logic [15:0] data);
		@(posedge mclk);
		cmd_rd <= 1'b1;
		cmd_code <= code;
		@(posedge mclk);
		cmd_rd <= 1'b0;
		cmd_code <= ~code;
		@(negedge mclk);
		data = cmd_rd_ack ? cmd_rdata : 16'hxxxx;
	endtask
endmodule // pmbus_host_model

// ### dv/overtemp_fault_supervisor_test.sv
`timescale 1ns/10ps
`include "overtemp_defs.svh"
module overtemp_fault_supervisor_test
	import overtemp_pkg::*;
;
	typedef struct packed {logic [15:0] flim, wlim, temp; logic f, w;} row_t;
	localparam logic [7:0] lim_f = `CMD_FAULT_LIMIT;
	localparam logic [7:0] lim_w = `CMD_WARN_LIMIT;
	localparam logic [7:0] act = `CMD_FAULT_ACTION;
	localparam logic [7:0] sts = `CMD_TEMP_STATUS;
	logic         mclk, rst, cmd_wr, cmd_rd, cmd_rd_ack, nvm_load, nvm_store, temp_valid;
	logic         clear_faults, output_on, start_done, shutdown, restart_pulse, temp_summary, alert_req;
	logic [7:0]   cmd_code, nvm_action, ton_rise_ms, nvm_action_image;
	logic [15:0]  cmd_wdata, cmd_rdata, nvm_fault_word, nvm_warn_word, temp_sample;
	logic [15:0]  nvm_fault_image, nvm_warn_image;
	temp_status_t status;
	int           num_errors = 0;
	int           checks_done = 0;
	int           n;
	row_t rows[8] = '{
		'{16'h0050, 16'h0046, 16'h0040, 1'b0, 1'b0},
		'{16'h0050, 16'h0046, 16'h0048, 1'b0, 1'b1},
		'{16'h0050, 16'h0046, 16'h0050, 1'b1, 1'b1},
		'{16'hf8a1, 16'h0046, 16'h0050, 1'b0, 1'b1},
		'{16'hf8a1, 16'h0046, 16'hf8a1, 1'b1, 1'b1},
		'{16'h00ff, 16'h0046, 16'h0096, 1'b0, 1'b1},
		'{16'h0050, 16'h00ff, 16'h0096, 1'b1, 1'b0},
		'{16'h0050, 16'h0046, 16'h0046, 1'b0, 1'b1}
	};

	overtemp_fault_supervisor #(.MS_CYCLES(20)) overtemp_fault_supervisor_i (.*);
	pmbus_host_model pmbus_host_model_i (.*);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic summarize();
		$display("checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_bit(input string what, input logic exp, input logic got);
		cmp(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	task automatic rd(input string what, input logic [7:0] code, input logic [15:0] exp);
		logic [15:0] d;
		pmbus_host_model_i.get(code, d);
		cmp(what, exp, d);
	endtask

	task automatic wr(input logic [7:0] code, input logic [15:0] d);
		pmbus_host_model_i.put(code, d);
	endtask

	task automatic sample(input logic [15:0] t);
		@(posedge mclk);
		temp_sample <= t;
		temp_valid <= 1'b1;
		@(posedge mclk);
		temp_valid <= 1'b0;
		repeat (2) @(negedge mclk);
	endtask

	task automatic clr();
		@(posedge mclk);
		clear_faults <= 1'b1;
		@(posedge mclk);
		clear_faults <= 1'b0;
	endtask

	// disable and re-enable the output, then clear the flags
	task automatic cycle_out();
		@(posedge mclk);
		output_on <= 1'b0;
		repeat (3) @(posedge mclk);
		output_on <= 1'b1;
		clr();
	endtask

	task automatic watch_restart(input logic exp);
		logic seen;
		seen = 1'b0;
		repeat (200) begin
			@(negedge mclk);
			if (restart_pulse === 1'b1)
				seen = 1'b1;
		end
		cmp_bit("restart", exp, seen);
	endtask

	initial begin
		rst = 1'b1;
		{nvm_load, nvm_store, temp_valid, clear_faults, start_done} = 5'h00;
		output_on = 1'b1;
		nvm_fault_word = 16'h00c8;
		nvm_warn_word = 16'hf119;
		nvm_action = 8'h00;
		ton_rise_ms = 8'h02;
		temp_sample = 16'h0000;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd("fault limit", lim_f, 16'h00a0);
		rd("warn limit", lim_w, 16'h0046);
		rd("action", act, 16'h0000);
		rd("status", sts, 16'h0000);
		rd("unmapped", 8'h60, 16'h0000);
		foreach (rows[i]) begin
			wr(lim_f, rows[i].flim);
			wr(lim_w, rows[i].wlim);
			clr();
			sample(rows[i].temp);
			cmp_bit("fault flag", rows[i].f, status.temp_fault_flag);
			cmp_bit("warn flag", rows[i].w, status.temp_warning_flag);
			cmp_bit("ignored", 1'b0, shutdown);
			cmp_bit("summary", rows[i].f | rows[i].w, temp_summary);
			rd("warn readback", lim_w, rows[i].wlim);
		end
		clr();
		wr(lim_w, 16'h00a1);
		rd("warn kept", lim_w, 16'h0046);
		rd("status", sts, 16'h0002);
		cmp_bit("alert", 1'b1, alert_req);
		clr();
		wr(lim_f, 16'h07ff);
		rd("fault kept", lim_f, 16'h0050);
		cmp_bit("invalid", 1'b1, status.invalid_data);
		wr(lim_f, 16'hf147);
		wr(lim_w, 16'h00ff);
		pmbus_host_model_i.put_byte(act, 8'h8a);
		@(posedge mclk);
		nvm_store <= 1'b1;
		@(posedge mclk);
		nvm_store <= 1'b0;
		repeat (2) @(negedge mclk);
		cmp("fault image", 16'h0052, nvm_fault_image);
		cmp("warn image", 16'h00ff, nvm_warn_image);
		cmp("action image", 16'h008a, {8'h00, nvm_action_image});
		rd("action", act, 16'h008a);
		@(posedge mclk);
		nvm_load <= 1'b1;
		@(posedge mclk);
		nvm_load <= 1'b0;
		rd("restored", lim_f, 16'h00a0);
		// hot at hiccup end with release twenty below the fault limit
		wr(lim_f, 16'h0050);
		wr(lim_w, 16'h00ff);
		pmbus_host_model_i.put_byte(act, 8'h88);
		cycle_out();
		sample(16'h0055);
		@(negedge mclk);
		cmp_bit("shutdown", 1'b1, shutdown);
		sample(16'h0041);
		watch_restart(1'b0);
		cmp_bit("latched", 1'b1, shutdown);
		// same temperature is cool against the warning limit
		wr(lim_w, 16'h0046);
		cycle_out();
		@(negedge mclk);
		cmp_bit("re-enabled", 1'b0, shutdown);
		sample(16'h0055);
		sample(16'h0041);
		watch_restart(1'b1);
		cmp_bit("restarted", 1'b0, shutdown);
		// the single allowed attempt is spent: a new fault latches off
		sample(16'h0055);
		sample(16'h0041);
		watch_restart(1'b0);
		cmp_bit("relatched", 1'b1, shutdown);
		@(posedge mclk);
		start_done <= 1'b1;
		@(posedge mclk);
		start_done <= 1'b0;
		// delayed mode, three milliseconds
		pmbus_host_model_i.put_byte(act, 8'h43);
		cycle_out();
		sample(16'h0055);
		repeat (20) @(negedge mclk);
		cmp_bit("early off", 1'b0, shutdown);
		n = 0;
		while (shutdown !== 1'b1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		cmp_bit("delayed off", 1'b1, shutdown);
		// until cool: a clear between the thresholds keeps the output off
		pmbus_host_model_i.put_byte(act, 8'hc8);
		cycle_out();
		sample(16'h0055);
		sample(16'h004b);
		cmp_bit("held off", 1'b1, shutdown);
		clr();
		sample(16'h0041);
		watch_restart(1'b0);
		cmp_bit("stuck", 1'b1, shutdown);
		sample(16'h0055);
		sample(16'h0041);
		watch_restart(1'b1);
		summarize();
	end

	initial begin
		repeat (4000) @(posedge mclk);
		num_errors++;
		$display("unexpected timeout: expected end, seen none");
		summarize();
	end
endmodule // overtemp_fault_supervisor_test
